// File: hw/udirc_pkg.sv
/*
 * Package for the serial channel request-gating block: register offsets,
 * field positions, reset values and the carrier structs.
 * Assumes a 32-bit classic Wishbone register bus and one clock domain.
 */
package udirc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK   = 8'h08;
    localparam logic [7:0] OFS_CHANGE = 8'h0C;

    // Control register fields
    localparam int CTL_TX_DMA   = 15;
    localparam int CTL_RX_DMA   = 14;
    localparam int CTL_TX_IRQ   = 13;
    localparam int CTL_RX_IRQ   = 12;
    localparam int CTL_SPEC_ERR = 11;
    localparam int CTL_CTS_HI   = 10;
    localparam int CTL_CTS_LO   = 9;
    localparam int CTL_OVR_M    = 5;
    localparam int CTL_CTS_M    = 4;
    localparam int CTL_BRKS_M   = 3;
    localparam int CTL_TXSP_M   = 2;
    localparam int CTL_ALLS_M   = 1;
    localparam int CTL_BRKD_M   = 0;
    localparam logic [31:0] CTL_WMASK = 32'h0000FE3F;
    localparam logic [31:0] CTL_RESET = 32'h00000000;

    // Status register fields
    localparam int ST_BREAK = 15;
    localparam int ST_ERRF  = 10;
    localparam int ST_TOUT  = 9;
    localparam int ST_TDIS  = 8;
    localparam int ST_RDIS  = 7;
    localparam int ST_CHGF  = 6;
    localparam logic [31:0] ST_STICKY = 32'h00000640;
    localparam logic [31:0] MASK_RESET = 32'h00000000;

    // Status change register fields
    localparam int CH_OERS  = 5;
    localparam int CH_CTSS  = 4;
    localparam int CH_RBRKD = 3;
    localparam int CH_TRDY  = 2;
    localparam int CH_TXALS = 1;
    localparam int CH_UBRKD = 0;

    // CTS condition select codes
    localparam logic [1:0] CTS_OFF  = 2'h0;
    localparam logic [1:0] CTS_RISE = 2'h1;
    localparam logic [1:0] CTS_FALL = 2'h2;
    localparam logic [1:0] CTS_BOTH = 2'h3;

    // Channel events from the serial core
    typedef struct packed {
        logic frame_err;
        logic parity_err;
        logic overrun_err;
        logic rx_timeout;
        logic break_detect;
        logic break_state;
        logic tx_space;
        logic rx_data;
        logic all_sent;
    } udirc_evt_t;

    // Requests to the interrupt and DMA controllers
    typedef struct packed {
        logic tx_dma;
        logic rx_dma;
        logic tx_interrupt;
        logic rx_interrupt;
        logic exception_interrupt;
    } udirc_req_t;

endpackage

// File: hw/udirc_sync3.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk_i; the output moves only
 * when the second and third stages agree.
 */
`timescale 1ns/1ns
module udirc_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pin and filtered level
    input  wire logic pin_i,
    output logic      level_o
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic level_d;

    always_comb begin
        level_d = level_q;
        if (s2_q == s3_q) begin
            level_d = s3_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q    <= RESET_VAL;
            s2_q    <= RESET_VAL;
            s3_q    <= RESET_VAL;
            level_q <= RESET_VAL;
        end else begin
            s1_q    <= pin_i;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;

endmodule

// File: hw/udirc_top.sv
/*
 * Request gating for one serial channel: control, status, mask and
 * status change registers on classic Wishbone, DMA and interrupt requests.
 * Assumes event inputs on clk_i, except cts_pin_i which is asynchronous.
 */
// Added by the designer: the Wishbone slave port and the register addresses.
// Functional notes
// [R1] Transmit DMA request follows transmit FIFO free space when enabled.
// [R2] Receive DMA request follows receive FIFO data when enabled.
// [R3] Transmit interrupt follows transmit FIFO free space when enabled.
// [R4] Receive error or timeout: receive irq without DMA, else exception.
// [R5] Special error enable routes receive errors to exception interrupt.
// [R6] CTS select: 00 off, 01 rising, 10 falling, 11 both edges.
// [R7] Overrun mask: overrun raises exception and sets status-change flag.
// [R8] CTS mask: qualifying CTS edge raises exception, sets change flag.
// [R9] Break-state mask gates exception and flag for line in break.
// [R10] Break-detect mask gates exception and flag for break detection.
// [R11] Software keeps both break masks equal.
// [R12] Break detected with either break mask set gives exception at once.
// [R13] Transmit-space mask: free space raises exception, sets flag.
// [R14] All-sent mask: transmission complete raises exception, sets flag.
// [R15] Break masks do not affect the status change register.
// [R16] Status-change flag sets on any change of an enabled condition; break state, tx space and all sent set it only when they become true.
// [R17] Frame, parity or overrun error sets the error interrupt flag.
// [R18] Each request output is a level held while its cause remains.
`timescale 1ns/1ns
module udirc_top (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [7:0]          adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic      [31:0]         dat_o,
    output logic                     ack_o,
    // Channel events and CTS pin
    input  wire udirc_pkg::udirc_evt_t evt_i,
    input  wire logic                cts_pin_i,
    // Requests and summary interrupt
    output udirc_pkg::udirc_req_t    req_o,
    output logic                     irq_o
);

    logic [31:0]           ctrl_q;
    logic [31:0]           ctrl_d;
    logic [31:0]           mask_q;
    logic [31:0]           mask_d;
    logic [31:0]           stat_q;
    logic [31:0]           stat_d;
    logic                  oers_q;
    logic                  oers_d;
    logic                  ubrkd_q;
    logic                  ubrkd_d;
    logic [31:0]           rdat_q;
    logic [31:0]           rdat_d;
    logic                  ack_q;
    logic                  ack_d;
    logic [3:0]            prev_q;
    logic [3:0]            prev_d;
    logic                  irq_q;
    logic                  irq_d;
    udirc_pkg::udirc_req_t req_q;
    udirc_pkg::udirc_req_t req_d;
    logic                  cts_lvl;
    logic                  cts_rise;
    logic                  cts_fall;
    logic                  cts_evt;
    logic                  rx_err;
    logic                  change_evt;
    logic                  wr_take;
    logic                  rd_take;
    logic [31:0]           wmask;
    logic [31:0]           live_stat;
    logic [31:0]           live_chg;

    // CTS pin synchroniser
    udirc_sync3 #(
        .RESET_VAL (1'b0)
    ) u_cts_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (cts_pin_i),
        .level_o (cts_lvl)
    );

    // Edge sources: cts, break state, tx space, all sent
    assign cts_rise = cts_lvl & ~prev_q[0];
    assign cts_fall = ~cts_lvl & prev_q[0];

    always_comb begin
        cts_evt = 1'b0;
        case (ctrl_q[udirc_pkg::CTL_CTS_HI:udirc_pkg::CTL_CTS_LO])
            udirc_pkg::CTS_OFF:  cts_evt = 1'b0;              // [R6]
            udirc_pkg::CTS_RISE: cts_evt = cts_rise;          // [R6]
            udirc_pkg::CTS_FALL: cts_evt = cts_fall;          // [R6]
            udirc_pkg::CTS_BOTH: cts_evt = cts_rise | cts_fall; // [R6]
            default:             cts_evt = 1'b0;
        endcase
    end

    assign rx_err = evt_i.frame_err | evt_i.parity_err
                  | evt_i.overrun_err;                        // [R17]

    // Masked status changes that set the status-change flag
    assign change_evt =
          (ctrl_q[udirc_pkg::CTL_OVR_M] & evt_i.overrun_err)  // [R7]
        | (ctrl_q[udirc_pkg::CTL_CTS_M] & cts_evt)            // [R8]
        | (ctrl_q[udirc_pkg::CTL_BRKS_M] & evt_i.break_state
           & ~prev_q[1])                                      // [R9]
        | (ctrl_q[udirc_pkg::CTL_BRKD_M] & evt_i.break_detect) // [R10]
        | (ctrl_q[udirc_pkg::CTL_TXSP_M] & evt_i.tx_space
           & ~prev_q[2])                                      // [R13]
        | (ctrl_q[udirc_pkg::CTL_ALLS_M] & evt_i.all_sent
           & ~prev_q[3]);                                     // [R14] [R16]

    // Bus handshake: answer one cycle after the request, act at the ack
    assign wr_take = cyc_i & stb_i & we_i & ack_q;
    assign rd_take = cyc_i & stb_i & ~we_i & ack_q;
    assign wmask   = {{8{sel_i[3]}}, {8{sel_i[2]}},
                      {8{sel_i[1]}}, {8{sel_i[0]}}};

    always_comb begin
        live_stat = stat_q;
        live_stat[udirc_pkg::ST_BREAK] = evt_i.break_state;
        live_stat[udirc_pkg::ST_TDIS]  = evt_i.tx_space;
        live_stat[udirc_pkg::ST_RDIS]  = evt_i.rx_data;
        live_chg = 32'h00000000;
        live_chg[udirc_pkg::CH_OERS]  = oers_q;
        live_chg[udirc_pkg::CH_CTSS]  = cts_lvl;
        live_chg[udirc_pkg::CH_RBRKD] = evt_i.break_state;
        live_chg[udirc_pkg::CH_TRDY]  = evt_i.tx_space;
        live_chg[udirc_pkg::CH_TXALS] = evt_i.all_sent;
        live_chg[udirc_pkg::CH_UBRKD] = ubrkd_q;
    end

    always_comb begin
        ack_d  = cyc_i & stb_i & ~ack_q;
        rdat_d = rdat_q;
        if (cyc_i && stb_i && !ack_q) begin
            if (adr_i == udirc_pkg::OFS_CTRL) begin
                rdat_d = ctrl_q;
            end else if (adr_i == udirc_pkg::OFS_STATUS) begin
                rdat_d = live_stat;
            end else if (adr_i == udirc_pkg::OFS_MASK) begin
                rdat_d = mask_q;
            end else if (adr_i == udirc_pkg::OFS_CHANGE) begin
                rdat_d = live_chg;
            end else begin
                rdat_d = 32'h00000000;
            end
        end
    end

    // Register file; hardware set wins over software clear
    always_comb begin
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        stat_d  = stat_q;
        oers_d  = oers_q;
        ubrkd_d = ubrkd_q;
        if (wr_take && adr_i == udirc_pkg::OFS_CTRL) begin
            ctrl_d = (ctrl_q & ~(wmask & udirc_pkg::CTL_WMASK))
                   | (dat_i & wmask & udirc_pkg::CTL_WMASK);
        end else if (wr_take && adr_i == udirc_pkg::OFS_MASK) begin
            mask_d = (mask_q & ~(wmask & udirc_pkg::ST_STICKY))
                   | (dat_i & wmask & udirc_pkg::ST_STICKY);
        end else if (wr_take && adr_i == udirc_pkg::OFS_CHANGE) begin
            if (sel_i[0] && !dat_i[udirc_pkg::CH_OERS]) begin
                oers_d = 1'b0;
            end
            if (sel_i[0] && !dat_i[udirc_pkg::CH_UBRKD]) begin
                ubrkd_d = 1'b0;
            end
        end
        if (rd_take && adr_i == udirc_pkg::OFS_STATUS) begin
            stat_d = stat_q & ~(rdat_q & udirc_pkg::ST_STICKY);
        end
        if (rx_err) begin
            stat_d[udirc_pkg::ST_ERRF] = 1'b1;                // [R17]
        end
        if (evt_i.rx_timeout) begin
            stat_d[udirc_pkg::ST_TOUT] = 1'b1;
        end
        if (change_evt) begin
            stat_d[udirc_pkg::ST_CHGF] = 1'b1;                // [R16]
        end
        if (evt_i.overrun_err) begin
            oers_d = 1'b1;                                    // [R15]
        end
        if (evt_i.break_detect) begin
            ubrkd_d = 1'b1;                                   // [R15]
        end
        prev_d = {evt_i.all_sent, evt_i.tx_space,
                  evt_i.break_state, cts_lvl};
    end

    // Request levels toward the interrupt and DMA controllers
    always_comb begin
        req_d = '0;
        req_d.tx_dma = ctrl_q[udirc_pkg::CTL_TX_DMA]
                     & evt_i.tx_space;                        // [R1] [R18]
        req_d.rx_dma = ctrl_q[udirc_pkg::CTL_RX_DMA]
                     & evt_i.rx_data;                         // [R2] [R18]
        req_d.tx_interrupt = ctrl_q[udirc_pkg::CTL_TX_IRQ]
                           & evt_i.tx_space;                  // [R3]
        req_d.rx_interrupt = ctrl_q[udirc_pkg::CTL_RX_IRQ]
                           & ~ctrl_q[udirc_pkg::CTL_RX_DMA]
                           & (stat_q[udirc_pkg::ST_ERRF]
                              | stat_q[udirc_pkg::ST_TOUT]);  // [R4]
        req_d.exception_interrupt =
              (ctrl_q[udirc_pkg::CTL_RX_IRQ]
               & ctrl_q[udirc_pkg::CTL_RX_DMA]
               & (stat_q[udirc_pkg::ST_ERRF]
                  | stat_q[udirc_pkg::ST_TOUT]))              // [R4]
            | (ctrl_q[udirc_pkg::CTL_SPEC_ERR]
               & stat_q[udirc_pkg::ST_ERRF])                  // [R5]
            | stat_q[udirc_pkg::ST_CHGF]                      // [R7] [R8]
            | ((ctrl_q[udirc_pkg::CTL_BRKS_M]
                | ctrl_q[udirc_pkg::CTL_BRKD_M])
               & (evt_i.break_detect | ubrkd_q
                  | evt_i.break_state));                      // [R12]
        irq_d = |(stat_q & mask_q);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q  <= udirc_pkg::CTL_RESET;
            mask_q  <= udirc_pkg::MASK_RESET;
            stat_q  <= 32'h00000000;
            oers_q  <= 1'b0;
            ubrkd_q <= 1'b0;
            rdat_q  <= 32'h00000000;
            ack_q   <= 1'b0;
            prev_q  <= 4'h0;
            req_q   <= '0;
            irq_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            mask_q  <= mask_d;
            stat_q  <= stat_d;
            oers_q  <= oers_d;
            ubrkd_q <= ubrkd_d;
            rdat_q  <= rdat_d;
            ack_q   <= ack_d;
            prev_q  <= prev_d;
            req_q   <= req_d;
            irq_q   <= irq_d;
        end
    end

    assign dat_o = rdat_q;
    assign ack_o = ack_q;
    assign req_o = req_q;
    assign irq_o = irq_q;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    tx_dma_req_a: assert property ( // [R1]
        req_o.tx_dma == ($past(ctrl_q[15]) && $past(evt_i.tx_space)))
        else $error("tx dma request wrong");

    rx_dma_off_a: assert property ( // [R2]
        !ctrl_q[14] && !$rose(ctrl_q[14]) |=> !req_o.rx_dma)
        else $error("rx dma request while disabled");

    tx_irq_hold_a: assert property ( // [R3]
        ctrl_q[13] && evt_i.tx_space |=> req_o.tx_interrupt)
        else $error("tx interrupt not held");

    rx_route_a: assert property ( // [R4]
        req_o.rx_interrupt |-> !$past(ctrl_q[14]) && $past(ctrl_q[12]))
        else $error("rx interrupt with rx dma enabled");

    spec_err_a: assert property ( // [R5]
        ctrl_q[11] && stat_q[10] |=> req_o.exception_interrupt)
        else $error("special error not raised");

    cts_off_a: assert property ( // [R6]
        ctrl_q[10:9] == 2'h0 |-> !cts_evt)
        else $error("cts event while disabled");

    ovr_flag_a: assert property ( // [R7]
        evt_i.overrun_err && ctrl_q[5] |=> stat_q[6] ##1
        req_o.exception_interrupt)
        else $error("overrun did not set flag and exception");

    brk_exc_a: assert property ( // [R12]
        evt_i.break_detect && (ctrl_q[3] || ctrl_q[0]) |=>
        req_o.exception_interrupt)
        else $error("break exception late");

    chg_reg_a: assert property ( // [R15]
        evt_i.break_detect |=> live_chg[0])
        else $error("break detect not recorded");

    eri_set_a: assert property ( // [R17]
        evt_i.frame_err || evt_i.parity_err |=> stat_q[10])
        else $error("error flag not set");

    ack_pulse_a: assert property (
        ack_o |=> !ack_o)
        else $error("ack longer than one cycle");

endmodule

// File: verification/udirc_host_model.sv
/*
 * Host side of the request lines: a pending register that latches every
 * level request from the block, as the interrupt and DMA controllers do.
 * Assumes the same clock and synchronous reset as the block.
 */
`timescale 1ns/1ns
module udirc_host_model (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Requests from the block
    input  wire udirc_pkg::udirc_req_t req_i,
    input  wire logic                  irq_i,
    // Latched requests
    output logic [5:0]                 pend_o
);
    logic [5:0] pend_d;

    always_comb begin
        pend_d = pend_o | {irq_i, req_i};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_o <= 6'h00;
        end else begin
            pend_o <= pend_d;
        end
    end
endmodule

// File: verification/udirc_top_tb.sv
/*
 * Self-checking bench for udirc_top: Wishbone register tasks, event
 * stimulus, random control and FIFO levels, and a host pending model.
 * Assumes the package and the host model are compiled first.
 */
`timescale 1ns/1ns
module udirc_top_tb;
    logic                  clk_i, rst_i, cyc_i, stb_i, we_i;
    logic                  ack_o, cts_pin_i, irq_o;
    logic [7:0]            adr_i;
    logic [3:0]            sel_i;
    logic [31:0]           dat_i, dat_o, q, ctl;
    logic [5:0]            pend;
    udirc_pkg::udirc_evt_t evt_i;
    udirc_pkg::udirc_req_t req_o;
    int                    error_cnt, tests_run, seed, i, m, r;

    udirc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .evt_i(evt_i),
        .cts_pin_i(cts_pin_i), .req_o(req_o), .irq_o(irq_o));

    udirc_host_model host (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_o),
        .irq_i(irq_o), .pend_o(pend));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        tests_run++;
        if (seen !== e) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, e, seen);
        end
    endtask

    task final_report;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Classic single Wishbone cycle; read data lands in q
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask

    task pulse(input logic [8:0] pm);
        @(posedge clk_i);
        evt_i <= udirc_pkg::udirc_evt_t'(evt_i | pm);
        @(posedge clk_i);
        evt_i <= udirc_pkg::udirc_evt_t'(evt_i & ~pm);
    endtask

    task w(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    function automatic logic [31:0] exp_req(logic [31:0] c, logic tx,
                                            logic rx);
        return {27'h0, c[15] & tx, c[14] & rx, c[13] & tx, 2'b00};
    endfunction

    initial begin
        #(100 * 30000);
        error_cnt++;
        final_report;
    end

    initial begin
        seed = 32'h29dc;
        {cyc_i, stb_i, we_i, cts_pin_i} = 4'h0;
        {adr_i, sel_i, dat_i} = 44'h0;
        evt_i = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(udirc_pkg::OFS_CTRL);
        chk("ctrl rst", q, udirc_pkg::CTL_RESET);
        rd(udirc_pkg::OFS_MASK);
        chk("mask rst", q, udirc_pkg::MASK_RESET);
        chk("req rst", 32'(req_o), 32'h0);
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10);
        chk("unmapped", q, 32'h0);
        wr(udirc_pkg::OFS_MASK, 32'hFFFFFFFF);
        rd(udirc_pkg::OFS_MASK);
        chk("mask rw", q, udirc_pkg::ST_STICKY);
        wr(udirc_pkg::OFS_MASK, 32'h0);
        for (i = 0; i < 20; i++) begin
            ctl = $random(seed);
            ctl[0] = ctl[3];
            wr(udirc_pkg::OFS_CTRL, ctl);
            rd(udirc_pkg::OFS_CTRL);
            chk("ctrl rw", q, ctl & udirc_pkg::CTL_WMASK);
        end
        wr(udirc_pkg::OFS_CTRL, 32'h0);
        rd(udirc_pkg::OFS_STATUS);
        // Random enables against random FIFO levels
        for (i = 0; i < 40; i++) begin
            ctl = (i == 0) ? 32'hE000 : $random(seed) & 32'hE000;
            wr(udirc_pkg::OFS_CTRL, ctl);
            r = $random(seed);
            @(posedge clk_i);
            evt_i.tx_space <= r[0] | (i == 0);
            evt_i.rx_data  <= r[1] | (i == 0);
            w(3);
            chk("req", 32'(req_o),
                exp_req(ctl, evt_i.tx_space, evt_i.rx_data));
        end
        @(posedge clk_i);
        evt_i.tx_space <= 1'b0;
        evt_i.rx_data  <= 1'b0;
        // Receive timeout without DMA, frame error with DMA
        for (m = 0; m < 2; m++) begin
            wr(udirc_pkg::OFS_CTRL, m ? 32'h5000 : 32'h1000);
            pulse(m ? 9'h100 : 9'h020);
            w(4);
            chk("rx path", 32'({req_o.rx_interrupt,
                req_o.exception_interrupt}),
                m ? 32'h1 : 32'h2);
            w(6);
            chk("rx held", 32'({req_o.rx_interrupt,
                req_o.exception_interrupt}),
                m ? 32'h1 : 32'h2);
            rd(udirc_pkg::OFS_STATUS);
            chk("rx stat", q, m ? 32'h400 : 32'h200);
        end
        // Special error enable with parity error
        for (m = 0; m < 2; m++) begin
            wr(udirc_pkg::OFS_CTRL, m ? 32'h800 : 32'h0);
            pulse(9'h080);
            w(4);
            chk("spec err", 32'(req_o.exception_interrupt), m);
            rd(udirc_pkg::OFS_STATUS);
            chk("par stat", q, 32'h400);
        end
        // Overrun with and without its mask
        for (m = 0; m < 2; m++) begin
            wr(udirc_pkg::OFS_CTRL, m ? 32'h20 : 32'h0);
            pulse(9'h040);
            w(4);
            chk("ovr exc", 32'(req_o.exception_interrupt), m);
            rd(udirc_pkg::OFS_STATUS);
            chk("ovr stat", q, m ? 32'h440 : 32'h400);
            rd(udirc_pkg::OFS_CHANGE);
            chk("ovr chg", q, 32'h20);
            wr(udirc_pkg::OFS_CHANGE, 32'h0);
            w(3);
            chk("ovr clr", 32'(req_o.exception_interrupt), 0);
        end
        // Every CTS condition code against both edges
        for (m = 0; m < 4; m++) begin
            wr(udirc_pkg::OFS_CTRL, 32'h10 | (m << 9));
            rd(udirc_pkg::OFS_STATUS);
            @(posedge clk_i);
            cts_pin_i <= 1'b1;
            w(8);
            chk("cts rise", 32'(req_o.exception_interrupt), m & 1);
            rd(udirc_pkg::OFS_STATUS);
            chk("cts rise", 32'(q[6]), m & 1);
            rd(udirc_pkg::OFS_CHANGE);
            chk("cts lvl", 32'(q[4]), 32'h1);
            @(posedge clk_i);
            cts_pin_i <= 1'b0;
            w(8);
            rd(udirc_pkg::OFS_STATUS);
            chk("cts fall", 32'(q[6]), m >> 1);
        end
        // Break state and break detect, masks kept equal
        for (m = 0; m < 2; m++) begin
            wr(udirc_pkg::OFS_CTRL, m ? 32'h9 : 32'h0);
            @(posedge clk_i);
            evt_i.break_state <= 1'b1;
            w(4);
            chk("brk state", 32'(req_o.exception_interrupt), m);
            pulse(9'h010);
            w(3);
            chk("brk det", 32'(req_o.exception_interrupt), m);
            rd(udirc_pkg::OFS_CHANGE);
            chk("brk chg", q & 32'h9, 32'h9);
            @(posedge clk_i);
            evt_i.break_state <= 1'b0;
            wr(udirc_pkg::OFS_CHANGE, 32'h0);
            wr(udirc_pkg::OFS_CTRL, 32'h0);
            rd(udirc_pkg::OFS_STATUS);
            w(3);
            chk("brk clr", 32'(req_o.exception_interrupt), 0);
        end
        // Transmit space and all sent masks
        for (m = 0; m < 2; m++) begin
            wr(udirc_pkg::OFS_CTRL, m ? 32'h4 : 32'h2);
            @(posedge clk_i);
            evt_i.tx_space <= m[0];
            evt_i.all_sent <= !m[0];
            w(4);
            chk("tx mask exc", 32'(req_o.exception_interrupt), 1);
            rd(udirc_pkg::OFS_STATUS);
            chk("tx mask flag", 32'(q[6]), 1);
            @(posedge clk_i);
            evt_i.tx_space <= 1'b0;
            evt_i.all_sent <= 1'b0;
            wr(udirc_pkg::OFS_CTRL, 32'h0);
            rd(udirc_pkg::OFS_STATUS);
        end
        // Summary interrupt: raise, mask, clear by status read
        wr(udirc_pkg::OFS_CTRL, 32'h20);
        wr(udirc_pkg::OFS_MASK, 32'h40);
        pulse(9'h040);
        w(4);
        chk("irq set", 32'(irq_o), 1);
        wr(udirc_pkg::OFS_MASK, 32'h0);
        w(3);
        chk("irq masked", 32'(irq_o), 0);
        wr(udirc_pkg::OFS_MASK, 32'h400);
        w(3);
        chk("irq err", 32'(irq_o), 1);
        rd(udirc_pkg::OFS_STATUS);
        w(3);
        chk("irq clr", 32'(irq_o), 0);
        wr(udirc_pkg::OFS_CHANGE, 32'h0);
        wr(udirc_pkg::OFS_CTRL, 32'h0);
        chk("host pend", 32'(pend), 32'h3F);
        final_report;
    end
endmodule
